// >>> hio_map.vh
// Constants for the handler I/O interlock block: register offsets, fields, reset values, timing.
// Assumes one 100 MHz clock and a single AHB-Lite slave port with word access.
`ifndef HIO_MAP_VH
`define HIO_MAP_VH

// ==========================================================================
// Register byte offsets
`define HIO_OFS_PATTERN   8'h00
`define HIO_OFS_CONFIG    8'h04
`define HIO_OFS_COMMAND   8'h08
`define HIO_OFS_STATUS    8'h0C
`define HIO_OFS_LIMIT     8'h10

// ==========================================================================
// CONFIG fields
`define HIO_CFG_WIDTH3    0
`define HIO_CFG_L4_LO     1
`define HIO_CFG_L4M_LSB   2
`define HIO_CFG_L4M_MSB   3
`define HIO_CFG_EDGE_LSB  4
`define HIO_CFG_EDGE_MSB  5
`define HIO_CFG_OE_EN     6
`define HIO_CFG_AO_EN     7
`define HIO_CFG_AO_COUNT  8
`define HIO_CFG_UPD_END   9
`define HIO_CFG_BITS      10
`define HIO_CFG_RESET     10'h000

// Line four modes and arm edges
`define HIO_L4_PATTERN    2'h0
`define HIO_L4_EOT        2'h1
`define HIO_L4_BUSY       2'h2
`define HIO_EDGE_FALL     2'h0
`define HIO_EDGE_RISE     2'h1
`define HIO_EDGE_BOTH     2'h2

// COMMAND bits (write one to act)
`define HIO_CMD_KEY       0
`define HIO_CMD_CLEAR     1
`define HIO_CMD_TEST_DONE 2
`define HIO_CMD_MEAS_DONE 3
`define HIO_CMD_CYC_START 4
`define HIO_CMD_COUNT_END 5
`define HIO_CMD_ARM_EXIT  6

// STATUS bits
`define HIO_ST_SRC_ON     0
`define HIO_ST_TRIPPED    1
`define HIO_ST_BUSY       2
`define HIO_ST_ARM_SEEN   3
`define HIO_ST_LOCK_HI    4
`define HIO_ST_SOT_LVL    5
`define HIO_ST_AO_ACTIVE  6

// LIMIT register: bit 4 marks a failing part
`define HIO_LIM_FAIL      4

// ==========================================================================
// Timing
`define HIO_CLK_MHZ       100
`define HIO_RESP_US       100
`define HIO_RESP_CYC      (`HIO_RESP_US * `HIO_CLK_MHZ)
`define HIO_EOT_NS        10000
`define HIO_EOT_CYC       (`HIO_EOT_NS * `HIO_CLK_MHZ / 1000)

`endif

// >>> hio_interlock.v
// Handler I/O interlock: output pattern lines, start-of-test detect, fixture interlock, auto-off.
// Assumes an AHB-Lite master on the same clock and raw, asynchronous handler pins.
`timescale 1ns/1ns
`include "hio_map.vh"

module hio_interlock
(
	// Clock and reset
	input  wire        I_CLK,
	input  wire        I_RST_N,
	// AHB-Lite slave
	input  wire        I_HSEL,
	input  wire [31:0] I_HADDR,
	input  wire [1:0]  I_HTRANS,
	input  wire        I_HWRITE,
	input  wire [2:0]  I_HSIZE,
	input  wire        I_HREADY,
	input  wire [31:0] I_HWDATA,
	output wire        O_HREADYOUT,
	output wire        O_HRESP,
	output reg  [31:0] O_HRDATA,
	// Handler pins
	input  wire        I_START_OF_TEST,
	input  wire        I_INTERLOCK,
	output reg  [3:0]  O_LINE,
	// Source control
	output reg         O_SOURCE_ON,
	output reg         O_TEST_START
);

	// ======================================================================
	// Bus address phase capture
	reg        wr_pend;
	reg        rd_pend;
	reg [7:0]  addr_q;
	wire       take = I_HSEL && I_HREADY && I_HTRANS[1];

	// Zero wait states: every data phase completes in its first cycle
	assign O_HREADYOUT = 1'b1;
	assign O_HRESP     = 1'b0;

	always @(posedge I_CLK)
	begin
		if (!I_RST_N)
		begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			addr_q  <= 8'h00;
		end
		else
		begin
			wr_pend <= take && I_HWRITE;
			rd_pend <= take && !I_HWRITE;
			addr_q  <= I_HADDR[7:0];
		end
	end

	wire wr_pat = wr_pend && (addr_q == `HIO_OFS_PATTERN);
	wire wr_cfg = wr_pend && (addr_q == `HIO_OFS_CONFIG);
	wire wr_cmd = wr_pend && (addr_q == `HIO_OFS_COMMAND);
	wire wr_lim = wr_pend && (addr_q == `HIO_OFS_LIMIT);
	wire [6:0] cmd = wr_cmd ? I_HWDATA[6:0] : 7'h00;

	// ======================================================================
	// Pin synchronisers, three stages; second and third must agree
	reg [2:0] sot_sync;
	reg [2:0] lock_sync;
	reg       sot_lvl;
	reg       lock_hi;

	always @(posedge I_CLK)
	begin
		if (!I_RST_N)
		begin
			sot_sync  <= 3'h7;
			lock_sync <= 3'h7;
			sot_lvl   <= 1'b1;
			lock_hi   <= 1'b1; // Open lid assumed until seen closed
		end
		else
		begin
			sot_sync  <= {sot_sync[1:0], I_START_OF_TEST};
			lock_sync <= {lock_sync[1:0], I_INTERLOCK};
			if (sot_sync[1] == sot_sync[2])
				sot_lvl <= sot_sync[2];
			if (lock_sync[1] == lock_sync[2])
				lock_hi <= lock_sync[2];
		end
	end

	// ======================================================================
	// Configuration and pattern registers
	reg [9:0]  cfg;
	reg [3:0]  pattern;
	reg [3:0]  lim_pat;
	reg        lim_fail;
	reg        lim_pend;

	wire       width3  = cfg[`HIO_CFG_WIDTH3];
	wire [1:0] l4_mode = cfg[`HIO_CFG_L4M_MSB:`HIO_CFG_L4M_LSB];
	wire [1:0] edge_sel = cfg[`HIO_CFG_EDGE_MSB:`HIO_CFG_EDGE_LSB];
	wire       oe_en   = cfg[`HIO_CFG_OE_EN];
	// Three-bit mode drops the top bit so only values 0-7 survive
	wire [3:0] pat_mask = width3 ? 4'h7 : 4'hF;

	always @(posedge I_CLK)
	begin
		if (!I_RST_N)
		begin
			cfg      <= `HIO_CFG_RESET;
			pattern  <= 4'h0;
			lim_pat  <= 4'h0;
			lim_fail <= 1'b0;
			lim_pend <= 1'b0;
		end
		else
		begin
			if (wr_cfg)
				cfg <= I_HWDATA[`HIO_CFG_BITS-1:0];
			// Key-off while on drops auto-off; it stays off until software sets it again
			else if (cmd[`HIO_CMD_KEY] && O_SOURCE_ON)
				cfg[`HIO_CFG_AO_EN] <= 1'b0;
			// Held until a write, a clear or a limit result replaces it
			if (cmd[`HIO_CMD_CLEAR])
				pattern <= 4'h0;
			else if (wr_pat)
				pattern <= I_HWDATA[3:0] & pat_mask;
			else if (wr_lim && (!cfg[`HIO_CFG_UPD_END] ||
				I_HWDATA[`HIO_LIM_FAIL] == 1'b0))
				pattern <= I_HWDATA[3:0] & pat_mask;
			else if (lim_pend && cmd[`HIO_CMD_TEST_DONE])
				pattern <= lim_pat;
			// End-of-sweep mode: remember the first limit result, pass or fail, until sweep end
			if (wr_lim && cfg[`HIO_CFG_UPD_END] && !lim_pend)
			begin
				lim_pat  <= I_HWDATA[3:0] & pat_mask;
				lim_fail <= I_HWDATA[`HIO_LIM_FAIL];
				lim_pend <= 1'b1;
			end
			else if (cmd[`HIO_CMD_TEST_DONE] || cmd[`HIO_CMD_CLEAR])
				lim_pend <= 1'b0;
		end
	end

	// ======================================================================
	// Start-of-test edge detection and busy / end-of-test timing
	reg        sot_prev;
	reg        busy;
	reg        arm_seen;
	reg [9:0]  eot_cnt;
	// Pulse length cut to the counter width on purpose;
	// the count fits in ten bits, so the dropped upper bits are zero
	localparam [31:0] eot_full = `HIO_EOT_CYC;
	wire       fall = sot_prev && !sot_lvl;
	wire       rise = !sot_prev && sot_lvl;
	reg        arm_evt;

	// Edge selection for the arm event
	always @*
	begin
		case (edge_sel)
			`HIO_EDGE_FALL: arm_evt = fall;
			`HIO_EDGE_RISE: arm_evt = rise;
			`HIO_EDGE_BOTH: arm_evt = fall || rise;
			default:        arm_evt = 1'b0;
		endcase
	end

	always @(posedge I_CLK)
	begin
		if (!I_RST_N)
		begin
			sot_prev     <= 1'b1;
			busy         <= 1'b0;
			arm_seen     <= 1'b0;
			eot_cnt      <= 10'h000;
			O_TEST_START <= 1'b0;
		end
		else
		begin
			sot_prev     <= sot_lvl;
			O_TEST_START <= arm_evt && !busy;
			if (arm_evt && !busy)
				busy <= 1'b1;
			else if (cmd[`HIO_CMD_TEST_DONE])
				busy <= 1'b0;
			// Set wins over a simultaneous clear by status read
			if (arm_evt)
				arm_seen <= 1'b1;
			else if (rd_pend && addr_q == `HIO_OFS_STATUS)
				arm_seen <= 1'b0;
			if (cmd[`HIO_CMD_TEST_DONE])
				eot_cnt <= eot_full[9:0];
			else if (eot_cnt != 10'h000)
				eot_cnt <= eot_cnt - 10'h001;
		end
	end

	// ======================================================================
	// Output lines; line four may be a timed END_OF_TEST_PULSE pulse or the busy level
	reg line4_act;

	always @*
	begin
		case (l4_mode)
			`HIO_L4_EOT:  line4_act = (eot_cnt != 10'h000);
			`HIO_L4_BUSY: line4_act = busy;
			default:      line4_act = 1'b0;
		endcase
	end

	always @(posedge I_CLK)
	begin
		if (!I_RST_N)
			O_LINE <= 4'h0;
		else
		begin
			O_LINE[2:0] <= pattern[2:0];
			if (l4_mode == `HIO_L4_PATTERN)
				O_LINE[3] <= pattern[3] & !width3;
			else
				O_LINE[3] <= line4_act ^ cfg[`HIO_CFG_L4_LO];
		end
	end

	// ======================================================================
	// Source output control: key, interlock and auto-off
	reg  src_req;   // User wants the source on
	reg  tripped;
	reg  ao_off;    // Auto-off currently holding the source off
	wire lock_open = oe_en && lock_hi;

	always @(posedge I_CLK)
	begin
		if (!I_RST_N)
		begin
			src_req     <= 1'b0;
			tripped     <= 1'b0;
			ao_off      <= 1'b0;
			O_SOURCE_ON <= 1'b0;
		end
		else
		begin
			if (lock_open && src_req)
			begin
				src_req <= 1'b0;
				tripped <= 1'b1;
			end
			else if (cmd[`HIO_CMD_KEY])
			begin
				if (O_SOURCE_ON)
					src_req <= 1'b0;
				else if (!lock_open)
				begin
					src_req <= 1'b1;
					tripped <= 1'b0;
				end
			end
			// Auto-off between cycles; a key-off cancels the policy
			if (cmd[`HIO_CMD_KEY] && O_SOURCE_ON)
				ao_off <= 1'b0;
			else if (cfg[`HIO_CFG_AO_EN])
			begin
				if (!cfg[`HIO_CFG_AO_COUNT])
				begin
					if (cmd[`HIO_CMD_CYC_START])
						ao_off <= 1'b0;
					else if (cmd[`HIO_CMD_MEAS_DONE])
						ao_off <= 1'b1;
				end
				else if (cmd[`HIO_CMD_CYC_START])
					ao_off <= 1'b0;
				else if (cmd[`HIO_CMD_COUNT_END])
					ao_off <= 1'b1;
			end
			else
				ao_off <= 1'b0;
			// Interlock drop is combined directly so off takes one cycle
			O_SOURCE_ON <= src_req && !lock_open && !ao_off &&
				!(cmd[`HIO_CMD_KEY] && O_SOURCE_ON);
		end
	end

	// Key-off while on also clears the auto-off enable bit
	wire ao_disable = cmd[`HIO_CMD_KEY] && O_SOURCE_ON && !wr_cfg;
	reg  ao_en_q;
	always @(posedge I_CLK)
	begin
		if (!I_RST_N)
			ao_en_q <= 1'b0;
		else
			ao_en_q <= ao_disable;
	end

	// ======================================================================
	// Read data mux
	always @*
	begin
		O_HRDATA = 32'h0000_0000;
		case (addr_q)
			`HIO_OFS_PATTERN: O_HRDATA[3:0] = O_LINE;
			`HIO_OFS_CONFIG:  O_HRDATA[`HIO_CFG_BITS-1:0] = cfg & ~{2'h0, ao_en_q, 7'h00};
			`HIO_OFS_STATUS:
			begin
				O_HRDATA[`HIO_ST_SRC_ON]    = O_SOURCE_ON;
				O_HRDATA[`HIO_ST_TRIPPED]   = tripped;
				O_HRDATA[`HIO_ST_BUSY]      = busy;
				O_HRDATA[`HIO_ST_ARM_SEEN]  = arm_seen;
				O_HRDATA[`HIO_ST_LOCK_HI]   = lock_hi;
				O_HRDATA[`HIO_ST_SOT_LVL]   = sot_lvl;
				O_HRDATA[`HIO_ST_AO_ACTIVE] = ao_off;
			end
			`HIO_OFS_LIMIT:   O_HRDATA[4:0] = {lim_fail, lim_pat};
			default:          O_HRDATA = 32'h0000_0000;
		endcase
	end

endmodule

// >>> hio_handler.sv
// Handler and fixture switch model on the handler pins
// Assumes the bench sets wanted levels just after a clock edge
`timescale 1ns/1ns
module hio_handler
(
	// Bench controls
	input  wire i_clk,
	input  wire i_sot_lvl,
	input  wire i_lid_open,
	// Pins toward the block
	output reg  o_sot,
	output reg  o_lock
);
	// Idle high start line, closed lid pulls the lock line low
	initial
	begin
		o_sot = 1'b1;
		o_lock = 1'b0;
	end
	// One clean step mid-cycle: no bounce reaches the edge-sensitive pins
	always @(posedge i_clk)
	begin
		#3;
		o_sot = i_sot_lvl;
		o_lock = i_lid_open;
	end
endmodule

// >>> hio_asserts.sv
// Checker for pin, pulse and interlock relations
// Sees only the top ports; CONFIG is shadowed from bus writes
`timescale 1ns/1ns
module hio_asserts
(
	// Watched ports
	input wire        I_CLK,
	input wire        I_RST_N,
	input wire        I_HSEL,
	input wire [31:0] I_HADDR,
	input wire [1:0]  I_HTRANS,
	input wire        I_HWRITE,
	input wire        I_HREADY,
	input wire [31:0] I_HWDATA,
	input wire        O_HREADYOUT,
	input wire        O_HRESP,
	input wire        I_START_OF_TEST,
	input wire        I_INTERLOCK,
	input wire [3:0]  O_LINE,
	input wire        O_SOURCE_ON,
	input wire        O_TEST_START
);
	reg       wr_dp;
	reg [7:0] wr_ofs;
	reg [9:0] cfg;
	reg       sot_q;
	reg [3:0] since;
	// Shadow CONFIG and age of the last start pin change
	always @(posedge I_CLK)
	begin
		wr_dp <= I_RST_N & I_HSEL & I_HREADY & I_HTRANS[1] & I_HWRITE;
		wr_ofs <= I_HADDR[7:0];
		sot_q <= I_START_OF_TEST;
		if (!I_RST_N)
			cfg <= 10'h000;
		else if (wr_dp && wr_ofs == 8'h04)
			cfg <= I_HWDATA[9:0];
		if (!I_RST_N || sot_q != I_START_OF_TEST)
			since <= 4'h0;
		else if (since != 4'hF)
			since <= since + 4'h1;
	end
	sequence s_lock_open;
		cfg[6] && I_INTERLOCK;
	endsequence
	property p_lock_off;
		@(posedge I_CLK) disable iff (!I_RST_N) s_lock_open [*8] |-> !O_SOURCE_ON;
	endproperty
	a_lock_off: assert property (p_lock_off) else $error("source on with lock open");
	property p_on_cause;
		@(posedge I_CLK) disable iff (!I_RST_N) $rose(O_SOURCE_ON) |-> $past(wr_dp) || $past(wr_dp, 2) || $past(wr_dp, 3);
	endproperty
	a_on_cause: assert property (p_on_cause) else $error("source on without command");
	property p_line_cause;
		@(posedge I_CLK) disable iff (!I_RST_N) $changed(O_LINE[2:0]) |-> $past(wr_dp) || $past(wr_dp, 2) || $past(wr_dp, 3);
	endproperty
	a_line_cause: assert property (p_line_cause) else $error("lines moved without write");
	property p_three;
		@(posedge I_CLK) disable iff (!I_RST_N) $changed(O_LINE) && cfg[0] && cfg[3:2] == 2'h0 |-> !O_LINE[3];
	endproperty
	a_three: assert property (p_three) else $error("line four set in 3-bit mode");
	property p_pulse;
		@(posedge I_CLK) disable iff (!I_RST_N) O_TEST_START |=> !O_TEST_START;
	endproperty
	a_pulse: assert property (p_pulse) else $error("start pulse too long");
	property p_start;
		@(posedge I_CLK) disable iff (!I_RST_N) O_TEST_START |-> since >= 4'h1 && since <= 4'h8;
	endproperty
	a_start: assert property (p_start) else $error("start without pin edge");
	property p_reset;
		@(posedge I_CLK) !I_RST_N |=> O_LINE == 4'h0 && !O_SOURCE_ON && !O_TEST_START;
	endproperty
	a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
	property p_okay;
		@(posedge I_CLK) disable iff (!I_RST_N) O_HREADYOUT && !O_HRESP;
	endproperty
	a_okay: assert property (p_okay) else $error("bus not ready or not okay");
endmodule
bind hio_interlock hio_asserts hio_asserts_i (.I_CLK, .I_RST_N, .I_HSEL, .I_HADDR, .I_HTRANS, .I_HWRITE,
	.I_HREADY, .I_HWDATA, .O_HREADYOUT, .O_HRESP, .I_START_OF_TEST, .I_INTERLOCK, .O_LINE, .O_SOURCE_ON,
	.O_TEST_START);

// >>> test_handler_io_interlock.sv
// Testbench: AHB-Lite tasks, handler model, one task per scenario
// Assumes hio_interlock, hio_map.vh and hio_handler are compiled first
`timescale 1ns/1ns
`include "hio_map.vh"
module test_handler_io_interlock;
	reg         I_CLK = 1'b0;
	reg         I_RST_N = 1'b0;
	reg         I_HSEL = 1'b0;
	reg  [31:0] I_HADDR = 32'h0;
	reg  [1:0]  I_HTRANS = 2'h0;
	reg         I_HWRITE = 1'b0;
	reg  [31:0] I_HWDATA = 32'h0;
	reg         sot_lvl = 1'b1;
	reg         lid_open = 1'b0;
	reg  [31:0] rd;
	wire        rdy, start_of_test_input, lock, src;
	wire        tst;
	wire [31:0] hrdata;
	wire [3:0]  line;
	integer     num_errors = 0;
	integer     samples_checked = 0;
	// Design and handler; the one slave's ready is the bus ready
	hio_interlock hio_interlock_i (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR),
		.I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HSIZE(3'h2), .I_HREADY(rdy), .I_HWDATA(I_HWDATA),
		.O_HREADYOUT(rdy), .O_HRESP(), .O_HRDATA(hrdata), .I_START_OF_TEST(start_of_test_input), .I_INTERLOCK(lock),
		.O_LINE(line), .O_SOURCE_ON(src), .O_TEST_START(tst));
	hio_handler hio_handler_i (.i_clk(I_CLK), .i_sot_lvl(sot_lvl), .i_lid_open(lid_open), .o_sot(start_of_test_input),
		.o_lock(lock));
	// 100 MHz clock and a hang limit far above the run length
	initial
	begin
		forever #5 I_CLK = ~I_CLK;
	end
	initial
	begin
		#900000;
		num_errors++;
		tally_and_finish;
	end
	task tally_and_finish;
		if (num_errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(string w, logic [31:0] e, logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("BAD %s exp %h got %h", w, e, g);
		end
	endtask
	// Bounded waits: a limit that runs out ends the run
	task edge_rdy;
		@(posedge I_CLK);
		for (int n = 0; rdy !== 1'b1; n++)
		begin
			if (n == 64)
			begin
				num_errors++;
				tally_and_finish;
			end
			@(posedge I_CLK);
		end
	endtask
	task wait_eq(string w, bit sel, logic [3:0] e);
		int n;
		for (n = 0; n < 20 && (sel ? {3'h0, src} : line) !== e; n++)
			@(posedge I_CLK);
		chk(w, e, sel ? {3'h0, src} : line);
		if (n == 20)
			tally_and_finish;
	endtask
	// Single word transfer; address phase held until ready, read data taken at the closing edge
	task xfer(bit w, logic [7:0] a, logic [31:0] d);
		I_HSEL <= 1'b1;
		I_HTRANS <= 2'h2;
		I_HWRITE <= w;
		I_HADDR <= {24'h0, a};
		edge_rdy;
		I_HTRANS <= 2'h0;
		I_HWDATA <= d;
		edge_rdy;
		rd = hrdata;
	endtask
	task t_reset;
		chk("line", 4'h0, line);
		xfer(0, `HIO_OFS_CONFIG, 0);
		chk("cfg", 32'h0, rd);
		xfer(0, 8'h40, 0);
		chk("hole", 32'h0, rd);
	endtask
	task t_pattern;
		for (int v = 0; v < 16; v++)
		begin
			xfer(1, `HIO_OFS_PATTERN, v);
			wait_eq("pat", 0, v[3:0]);
		end
		xfer(1, `HIO_OFS_CONFIG, 32'h1);
		xfer(1, `HIO_OFS_PATTERN, 32'hD);
		wait_eq("pat3", 0, 4'h5);
		repeat (50) @(posedge I_CLK);
		chk("held", 4'h5, line);
		xfer(1, `HIO_OFS_COMMAND, 32'h2);
		wait_eq("clear", 0, 4'h0);
	endtask
	// Line four end-of-test pulse, both polarities, 1000 cycles long
	task t_eot;
		for (int p = 0; p < 2; p++)
		begin
			xfer(1, `HIO_OFS_CONFIG, 32'h4 | (p << 1));
			wait_eq("idle4", 0, {p[0], 3'h0});
			xfer(1, `HIO_OFS_COMMAND, 32'h4);
			wait_eq("eot", 0, {~p[0], 3'h0});
			repeat (980) @(posedge I_CLK);
			chk("eotlen", {~p[0], 3'h0}, line);
			repeat (30) @(posedge I_CLK);
			chk("eotend", {p[0], 3'h0}, line);
		end
	endtask
	// Each arm edge mode against a falling then a rising pin step, line four showing busy
	task t_arm;
		int n;
		for (int e = 0; e < 3; e++)
		begin
			xfer(1, `HIO_OFS_CONFIG, 32'h8 | (e << 4));
			for (int s = 0; s < 2; s++)
			begin
				sot_lvl <= s[0];
				n = 0;
				repeat (20)
				begin
					@(posedge I_CLK);
					n += (tst === 1'b1);
				end
				chk("starts", (e == 2 || e == s), n);
				chk("busy4", {(e == 2 || e == s), 3'h0}, line);
				xfer(1, `HIO_OFS_COMMAND, 32'h4);
			end
		end
	endtask
	task t_lock;
		xfer(1, `HIO_OFS_CONFIG, 32'h40);
		for (int k = 0; k < 3; k++)
		begin
			xfer(1, `HIO_OFS_COMMAND, 32'h1);
			wait_eq("key", 1, {3'h0, ~k[0]});
		end
		lid_open <= 1'b1;
		wait_eq("trip", 1, 0);
		xfer(1, `HIO_OFS_COMMAND, 32'h1);
		repeat (20) @(posedge I_CLK);
		chk("refuse", 0, src);
		lid_open <= 1'b0;
		repeat (20) @(posedge I_CLK);
		chk("stayoff", 0, src);
		xfer(1, `HIO_OFS_COMMAND, 32'h1);
		wait_eq("rearm", 1, 1);
		xfer(1, `HIO_OFS_CONFIG, 32'h0);
		lid_open <= 1'b1;
		repeat (20) @(posedge I_CLK);
		chk("noen", 1, src);
		lid_open <= 1'b0;
	endtask
	task t_auto;
		xfer(1, `HIO_OFS_COMMAND, 32'h8);
		wait_eq("aodis", 1, 1);
		xfer(1, `HIO_OFS_CONFIG, 32'h80);
		xfer(1, `HIO_OFS_COMMAND, 32'h8);
		wait_eq("meas", 1, 0);
		xfer(1, `HIO_OFS_COMMAND, 32'h10);
		wait_eq("cycle", 1, 1);
		xfer(1, `HIO_OFS_CONFIG, 32'h180);
		xfer(1, `HIO_OFS_COMMAND, 32'h8);
		repeat (10) @(posedge I_CLK);
		chk("count", 1, src);
		xfer(1, `HIO_OFS_COMMAND, 32'h20);
		wait_eq("cntend", 1, 0);
		xfer(1, `HIO_OFS_CONFIG, 32'h80);
		xfer(1, `HIO_OFS_COMMAND, 32'h10);
		wait_eq("cycle", 1, 1);
		xfer(1, `HIO_OFS_COMMAND, 32'h1);
		wait_eq("keyoff", 1, 0);
		xfer(1, `HIO_OFS_COMMAND, 32'h10);
		repeat (10) @(posedge I_CLK);
		chk("aooff", 0, src);
		xfer(0, `HIO_OFS_CONFIG, 0);
		chk("aoen", 32'h0, rd & 32'h80);
		xfer(1, `HIO_OFS_COMMAND, 32'h1);
		wait_eq("keyon", 1, 1);
		xfer(1, `HIO_OFS_COMMAND, 32'h8);
		repeat (10) @(posedge I_CLK);
		chk("aogone", 1, src);
	endtask
	// Limit result applied at once, or a failing one held until test done in end-of-sweep mode
	task t_limit;
		xfer(1, `HIO_OFS_CONFIG, 32'h0);
		xfer(1, `HIO_OFS_LIMIT, 32'h13);
		wait_eq("limimm", 0, 4'h3);
		xfer(1, `HIO_OFS_CONFIG, 32'h200);
		xfer(1, `HIO_OFS_LIMIT, 32'h15);
		xfer(0, `HIO_OFS_LIMIT, 0);
		chk("limheld", 32'h15, rd);
		chk("limwait", 4'h3, line);
		xfer(1, `HIO_OFS_LIMIT, 32'h02);
		wait_eq("limpass", 0, 4'h2);
		xfer(1, `HIO_OFS_COMMAND, 32'h4);
		wait_eq("limend", 0, 4'h5);
	endtask
	// Main sequence, ending with a reset in mid-run
	initial
	begin
		repeat (4) @(posedge I_CLK);
		I_RST_N <= 1'b1;
		t_reset;
		t_pattern;
		t_eot;
		t_arm;
		t_lock;
		t_auto;
		t_limit;
		I_RST_N <= 1'b0;
		repeat (4) @(posedge I_CLK);
		chk("rst", 5'h00, {line, src});
		I_RST_N <= 1'b1;
		@(posedge I_CLK);
		chk("rst2", 5'h00, {line, src});
		xfer(0, `HIO_OFS_CONFIG, 0);
		chk("cfg2", 32'h0, rd);
		tally_and_finish;
	end
endmodule
